// ==== hdl/bcr_pkg.sv ====
// package: register offsets, field positions, reset values and codes for the board control bank
package bcr_pkg;
  // i/o port offsets
  localparam logic [15:0] OFS_FUNCTION = 16'h8202;
  localparam logic [15:0] OFS_VARIANT  = 16'h8204;
  localparam logic [15:0] OFS_SETUP    = 16'h8205;
  localparam logic [15:0] OFS_REVISION = 16'h8206;
  localparam logic [15:0] OFS_WIN_CFG  = 16'h8207;
  localparam logic [15:0] OFS_WIN_PAGE = 16'h8208;
  localparam logic [15:0] OFS_WIN_BASE = 16'h8209;
  localparam logic [15:0] OFS_BOOT     = 16'h820A;
  localparam logic [15:0] OFS_TWO_WIRE = 16'h820B;

  // field positions
  localparam int SETUP_READY_BIT  = 7;
  localparam int SETUP_WDOG_BIT   = 6;
  localparam int WIN_ENABLE_BIT   = 7;
  localparam int WIN_SIZE_BIT     = 0;
  localparam int TW_CLK_LATCH_BIT = 7;
  localparam int TW_DAT_LATCH_BIT = 6;
  localparam int TW_CLK_PIN_BIT   = 5;
  localparam int TW_DAT_PIN_BIT   = 4;
  localparam int PAGE_W           = 3;
  localparam int BASE_W           = 6;

  // constants
  localparam logic [7:0] RESET_TRIGGER_CODE = 8'hA5;
  localparam logic [7:0] BASE_FIXED_HIGH    = 8'hC0;
  localparam logic [7:0] TW_LOW_NIBBLE      = 8'h0F;
  localparam logic [7:0] UNMAPPED_READ      = 8'hFF;
  localparam logic [1:0] BOOT_LOADER_MODE   = 2'h2;

  // reset values
  localparam logic [7:0] RST_WIN_CFG  = 8'h00;
  localparam logic [2:0] RST_PAGE     = 3'h0;
  localparam logic [5:0] RST_BASE     = 6'h00;
  localparam logic       RST_STOP     = 1'b1;
  localparam logic       RST_READY    = 1'b0;
  localparam logic       RST_LATCH    = 1'b1;

  // trigger source selection
  typedef enum logic [1:0] {
    BCR_SYNC_RESERVED = 2'b00,
    BCR_SYNC_TIMER    = 2'b01
  } bcr_sync_src_t;
endpackage : bcr_pkg

// ==== hdl/bcr_sync_mux.sv ====
// trigger and stop output logic toward the add-on board connector
`timescale 1ns/1ps
module bcr_sync_mux
  import bcr_pkg::*;
(
  // control bits
  input  wire logic sync_source_select,
  input  wire logic sync_direct_level,
  input  wire logic stop_state,
  input  wire logic boot_loader,
  // timer source
  input  wire logic timer_ch2,
  input  wire logic speaker_enable,
  // outputs
  output logic      sync_n,
  output logic      stop_n,
  output logic      stop_led_on
);
  logic stop_active;

  // trigger source selection
  always_comb
  begin
    if (sync_source_select)
      sync_n = sync_direct_level;                   // RL22
    else if (sync_direct_level)
      sync_n = timer_ch2 & speaker_enable;          // RL22
    else
      sync_n = 1'b1;  // no square wave source here  // RL4
  end

  // stop forced active in boot loader mode
  assign stop_active = stop_state | boot_loader;  // RL2 RL23
  assign stop_n      = ~stop_active;              // RL3
  assign stop_led_on = stop_active;               // RL1
endmodule : bcr_sync_mux

// ==== hdl/bcr_two_wire.sv ====
// bit-level two-wire port: output latches and live pin sampling
`timescale 1ns/1ps
module bcr_two_wire
  import bcr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // register access
  input  wire logic       wr_stb,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_value,
  // open-drain pins
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe
);
  logic clock_line_latch_q;
  logic data_line_latch_q;

  // latches: software alone sequences the bus, no hardware timing
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      clock_line_latch_q <= RST_LATCH;
      data_line_latch_q  <= RST_LATCH;
    end
    else if (clk_en && wr_stb)
    begin
      clock_line_latch_q <= wr_data[TW_CLK_LATCH_BIT];  // RL21 RL24
      data_line_latch_q  <= wr_data[TW_DAT_LATCH_BIT];  // RL21
    end
  end

  // latch at 0 pulls low, latch at 1 releases
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = ~clock_line_latch_q;  // RL21
  assign sda_oe  = ~data_line_latch_q;   // RL21

  // read view
  always_comb
  begin
    rd_value                   = TW_LOW_NIBBLE;  // RL20
    rd_value[TW_CLK_LATCH_BIT] = clock_line_latch_q;
    rd_value[TW_DAT_LATCH_BIT] = data_line_latch_q;
    rd_value[TW_CLK_PIN_BIT]   = scl_in;          // RL20
    rd_value[TW_DAT_PIN_BIT]   = sda_in;
  end
endmodule : bcr_two_wire

// ==== hdl/bcr_bank.sv ====
// board control register bank on the host i/o port bus
`timescale 1ns/1ps
// Behaviour
// [RL1] stop output lights red indicator when low
// [RL2] stop active after reset and in boot loader
// [RL3] stop and trigger exported to expansion connector
// [RL4] no square wave trigger source provided
// [RL5] function code read fixed, writes ignored
// [RL6] variant code read fixed
// [RL7] writing A5 to variant register resets board
// [RL8] setup reads ready bit7, watchdog bit6
// [RL9] watchdog enable sticks once set
// [RL10] ready bit drives active-low ready, green light
// [RL11] ready inactive after reset and boot loader
// [RL12] software preserves ready when enabling watchdog
// [RL13] revision register returns logic revision
// [RL14] window size bit0, bits6..1 read zero
// [RL15] window enable in config bit7
// [RL16] three-bit page select, upper bits zero
// [RL17] base bits 7..6 fixed one, 5..0 writable
// [RL18] boot mode pins read in bits 1..0
// [RL19] software never writes boot mode register
// [RL20] two-wire read: latches, pins, low nibble ones
// [RL21] two-wire write loads latches, open-drain drive
// [RL24] two-wire bus sequenced by software only
// [RL22] trigger follows direct bit or gated timer
// [RL23] stop bit drives stop output low
// [RL25] reserved bits ignored, read constant
module bcr_bank
  import bcr_pkg::*;
#(
  parameter logic [7:0] FUNCTION_CODE = 8'h3C,  // value arbitrary
  parameter logic [7:0] VARIANT_CODE  = 8'h1E,  // value arbitrary
  parameter logic [7:0] REVISION_CODE = 8'h01   // value arbitrary
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // host i/o port bus
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_hit,
  // control register bits held elsewhere
  input  wire logic        sync_source_select,
  input  wire logic        sync_direct_level,
  input  wire logic        stop_state,
  input  wire logic        timer_ch2,
  input  wire logic        speaker_enable,
  // board pins
  input  wire logic [1:0]  boot_mode_pins,
  output logic             sync_n,
  output logic             stop_n,
  output logic             stop_led_on,
  output logic             ready_n,
  output logic             ready_led_on,
  output logic             board_reset_req,
  // watchdog and socket window
  output logic             watchdog_enable,
  output logic             window_enable,
  output logic             window_size,
  output logic [2:0]       window_page,
  output logic [7:0]       window_base,
  // two-wire pins
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);
  // access timing for whoever hooks this bank to a host bus:
  //   a read is taken at an enabled edge and its data stands from the next
  //   cycle until the next taken read; a write lands at its taking edge;
  //   accesses may follow back to back, there are no wait states.
  // the stop and trigger control bits sit in a control register outside
  // this bank and arrive here as plain levels.

  // register state
  logic              ready_q;
  logic              wdog_q;
  logic              win_en_q;
  logic              win_size_q;
  logic [PAGE_W-1:0] page_q;
  logic [BASE_W-1:0] base_q;
  logic              board_reset_q;
  logic [7:0]        rdata_q;
  logic [7:0]        rdata_d;
  // decoded strobes and read views
  logic              wr;
  logic              rd;
  logic              wr_variant;
  logic              wr_setup;
  logic              wr_win_cfg;
  logic              wr_win_page;
  logic              wr_win_base;
  logic              wr_two_wire;
  logic              reset_code_seen;
  logic              boot_loader;
  logic [7:0]        tw_value;
  logic [7:0]        setup_view;
  logic [7:0]        win_cfg_view;
  logic [7:0]        page_view;
  logic [7:0]        base_view;
  logic [7:0]        boot_view;

  // address match helper shared by decode paths; the match is exact, so
  // aliases of the bank further up the port space are not claimed
  function automatic logic hit_at(input logic [15:0] a, input logic [15:0] ofs);
    hit_at = (a == ofs);
  endfunction : hit_at

  // base address as the bus sees it: the top bits always read as one
  function automatic logic [7:0] base_with_fixed(input logic [BASE_W-1:0] b);
    base_with_fixed = BASE_FIXED_HIGH | {{(8-BASE_W){1'b0}}, b};  // RL17
  endfunction : base_with_fixed

  // strobes carry the clock enable, so a frozen bank ignores the bus
  // entirely instead of taking half an access
  assign wr          = clk_en & io_wr;
  assign rd          = clk_en & io_rd;
  assign wr_variant  = wr & hit_at(io_addr, OFS_VARIANT);
  assign wr_setup    = wr & hit_at(io_addr, OFS_SETUP);
  assign wr_win_cfg  = wr & hit_at(io_addr, OFS_WIN_CFG);
  assign wr_win_page = wr & hit_at(io_addr, OFS_WIN_PAGE);
  assign wr_win_base = wr & hit_at(io_addr, OFS_WIN_BASE);
  assign wr_two_wire = wr & hit_at(io_addr, OFS_TWO_WIRE);

  // function, revision and boot mode registers have no write path, so a
  // write to them falls through every decode below and changes nothing
  assign reset_code_seen = wr_variant & (io_wdata == RESET_TRIGGER_CODE);  // RL7
  assign boot_loader     = (boot_mode_pins == BOOT_LOADER_MODE);          // RL2 RL11

  // board reset request: one registered pulse, so a glitch on the data
  // lines while the write settles cannot reach the reset tree
  always_ff @(posedge clk)
  begin
    if (reset)
      board_reset_q <= 1'b0;
    else if (clk_en)
      board_reset_q <= reset_code_seen;  // RL7
  end

  // ready bit follows every setup write; software keeps it set when it
  // only means to start the watchdog
  always_ff @(posedge clk)
  begin
    if (reset)
      ready_q <= RST_READY;  // RL11
    else if (wr_setup)
      ready_q <= io_wdata[SETUP_READY_BIT];  // RL10
  end

  // watchdog enable is one-way: a written zero is dropped, so only a
  // board reset brings it back to zero; a runaway program cannot switch
  // off the very timer meant to catch it
  always_ff @(posedge clk)
  begin
    if (reset)
      wdog_q <= 1'b0;
    else if (wr_setup && io_wdata[SETUP_WDOG_BIT])
      wdog_q <= 1'b1;  // RL9
  end

  // window configuration: only the enable and size bits are stored,
  // the bits between them are not kept and read back as zero
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      win_en_q   <= RST_WIN_CFG[WIN_ENABLE_BIT];
      win_size_q <= RST_WIN_CFG[WIN_SIZE_BIT];
    end
    else if (wr_win_cfg)
    begin
      win_en_q   <= io_wdata[WIN_ENABLE_BIT];  // RL15
      win_size_q <= io_wdata[WIN_SIZE_BIT];    // RL14 RL25
    end
  end

  // page select: upper data bits are dropped on the way in, so a page
  // number beyond the socket memory simply wraps
  always_ff @(posedge clk)
  begin
    if (reset)
      page_q <= RST_PAGE;
    else if (wr_win_page)
      page_q <= io_wdata[PAGE_W-1:0];  // RL16
  end

  // base address: the fixed bits are not stored, so no write can move
  // the window below the top of the adapter area
  always_ff @(posedge clk)
  begin
    if (reset)
      base_q <= RST_BASE;
    else if (wr_win_base)
      base_q <= io_wdata[BASE_W-1:0];  // RL17
  end

  // read views with reserved bits tied to their constant values
  // rather than to whatever the host last wrote there
  assign setup_view   = {ready_q, wdog_q, 6'h00};        // RL8
  assign win_cfg_view = {win_en_q, 6'h00, win_size_q};   // RL14
  assign page_view    = {{(8-PAGE_W){1'b0}}, page_q};    // RL16
  assign base_view    = base_with_fixed(base_q);         // RL17
  assign boot_view    = {6'h00, boot_mode_pins};         // RL18

  // read multiplexer; an unclaimed address reads all ones, as an
  // undriven host data bus would
  always_comb
  begin
    rdata_d = UNMAPPED_READ;  // RL25
    case (io_addr)
      OFS_FUNCTION: rdata_d = FUNCTION_CODE;  // RL5
      OFS_VARIANT:  rdata_d = VARIANT_CODE;   // RL6
      OFS_SETUP:    rdata_d = setup_view;     // RL8
      OFS_REVISION: rdata_d = REVISION_CODE;  // RL13
      OFS_WIN_CFG:  rdata_d = win_cfg_view;   // RL14 RL15
      OFS_WIN_PAGE: rdata_d = page_view;      // RL16
      OFS_WIN_BASE: rdata_d = base_view;      // RL17
      OFS_BOOT:     rdata_d = boot_view;      // RL18
      OFS_TWO_WIRE: rdata_d = tw_value;       // RL20
      default:      rdata_d = UNMAPPED_READ;  // RL25
    endcase
  end

  // read data registered so the host sees a settled word one cycle later;
  // the live pin bits are sampled here, which costs a cycle of latency
  // but keeps the host data lines free of pin glitches
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_q <= 8'h00;
    else if (rd)
      rdata_q <= rdata_d;
  end

  // decode flag lets the host bus know this bank claimed the cycle
  always_comb
  begin
    io_hit = 1'b0;
    case (io_addr)
      OFS_FUNCTION, OFS_VARIANT, OFS_SETUP, OFS_REVISION, OFS_WIN_CFG,
      OFS_WIN_PAGE, OFS_WIN_BASE, OFS_BOOT, OFS_TWO_WIRE: io_hit = 1'b1;
      default: io_hit = 1'b0;
    endcase
  end

  // two-wire port: open drain, an output enable high pulls its line low;
  // start, stop and bit timing are left entirely to software
  bcr_two_wire bcr_two_wire_i (
    .clk      (clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .wr_stb   (wr_two_wire),
    .wr_data  (io_wdata),
    .rd_value (tw_value),
    .scl_in   (scl_in),
    .scl_out  (scl_out),
    .scl_oe   (scl_oe),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe)
  );

  // stop and trigger stay combinational so the connector follows the
  // control bits within the same cycle
  bcr_sync_mux bcr_sync_mux_i (
    .sync_source_select (sync_source_select),
    .sync_direct_level  (sync_direct_level),
    .stop_state         (stop_state),
    .boot_loader        (boot_loader),
    .timer_ch2          (timer_ch2),
    .speaker_enable     (speaker_enable),
    .sync_n             (sync_n),
    .stop_n             (stop_n),
    .stop_led_on        (stop_led_on)
  );

  // ready kept inactive in boot loader mode, whatever the bit holds;
  // the led mirrors the pin
  assign ready_n         = ~(ready_q & ~boot_loader);  // RL10 RL11
  assign ready_led_on    = ~ready_n;                   // RL10

  // registered read data and reset pulse toward the host side
  assign io_rdata        = rdata_q;
  assign board_reset_req = board_reset_q;  // RL7

  // watchdog and socket window settings toward the board logic
  assign watchdog_enable = wdog_q;      // RL9
  assign window_enable   = win_en_q;    // RL15
  assign window_size     = win_size_q;  // RL14
  assign window_page     = page_q;      // RL16
  assign window_base     = base_view;   // RL17
endmodule : bcr_bank

// ==== tb/bcr_sensor_model.sv ====
// two-wire bus model: pull-up lines and a sensor that may hold data low
`timescale 1ns/1ps
module bcr_sensor_model (
  // line drive from the bank
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // sensor side pull-down on data
  input  wire logic hold_low,
  // resolved line levels
  output logic      scl_line,
  output logic      sda_line
);
  // pull-ups: a released line reads high, any driver wins low
  assign scl_line = ~scl_oe;
  assign sda_line = ~(sda_oe | hold_low);
endmodule : bcr_sensor_model

// ==== tb/bcr_bank_props.sv ====
// port assertions for the board control bank
`timescale 1ns/1ps
module bcr_bank_props
  import bcr_pkg::*;
#(
  parameter logic [7:0] FUNCTION_CODE = 8'h3C  // value arbitrary
)
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        clk_en,
  // host bus
  input wire logic [15:0] io_addr,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_hit,
  // control inputs and outputs
  input wire logic        sync_source_select,
  input wire logic        sync_direct_level,
  input wire logic        stop_state,
  input wire logic        timer_ch2,
  input wire logic        speaker_enable,
  input wire logic [1:0]  boot_mode_pins,
  input wire logic        sync_n,
  input wire logic        stop_n,
  input wire logic        ready_n,
  input wire logic        board_reset_req,
  input wire logic        watchdog_enable,
  input wire logic [7:0]  window_base
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // reads are taken only with the enable, so every read antecedent carries it
  AST_STOP_FORCE: assert property (stop_n == !(stop_state || boot_mode_pins == 2'h2))
    else $error("stop output wrong");
  AST_READY_BOOT: assert property (boot_mode_pins == 2'h2 |-> ready_n)
    else $error("ready active in boot loader");
  AST_SYNC_DIRECT: assert property (sync_source_select |-> sync_n == sync_direct_level)
    else $error("trigger not direct");
  AST_SYNC_TIMER: assert property (!sync_source_select && sync_direct_level
    |-> sync_n == (timer_ch2 & speaker_enable)) else $error("trigger not timer");
  AST_RST_PULSE: assert property (clk_en && io_wr && io_addr == OFS_VARIANT
    && io_wdata == 8'hA5 |=> board_reset_req) else $error("no board reset pulse");
  AST_RST_CAUSE: assert property (board_reset_req |-> $past(clk_en && io_wr
    && io_addr == OFS_VARIANT && io_wdata == 8'hA5)) else $error("stray board reset");
  AST_WDOG_HOLD: assert property (watchdog_enable |=> watchdog_enable)
    else $error("watchdog disabled");
  AST_FUNC_READ: assert property (clk_en && io_rd && io_addr == OFS_FUNCTION
    |=> io_rdata == FUNCTION_CODE) else $error("function code wrong");
  AST_UNMAPPED: assert property (clk_en && io_rd && !io_hit
    |=> io_rdata == 8'hFF) else $error("unmapped read wrong");
  AST_BASE_READ: assert property (clk_en && io_rd && io_addr == OFS_WIN_BASE
    |=> io_rdata == window_base && io_rdata[7:6] == 2'b11) else $error("base wrong");
  AST_SETUP_READ: assert property (clk_en && io_rd && io_addr == OFS_SETUP
    |=> io_rdata[5:0] == 6'h00 && io_rdata[6] == watchdog_enable) else $error("setup");
endmodule : bcr_bank_props

// ==== tb/bcr_bank_tb.sv ====
// self-checking bench for the board control register bank
`timescale 1ns/1ps
module bcr_bank_tb import bcr_pkg::*;;
  localparam logic [7:0] FC = 8'h3C;  // value arbitrary
  localparam logic [7:0] VC = 8'h1E;  // value arbitrary
  localparam logic [7:0] RC = 8'h01;  // value arbitrary
  logic clk = 0, reset = 1, clk_en = 1, io_rd = 0, io_wr = 0, hold = 0;
  logic sel = 0, dir = 1, stop = 1, tmr = 0, spk = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00, rdat, wbase;
  logic [1:0] boot = 2'h3;
  logic [2:0] wpg;
  logic hit, sync_n, stop_n, stop_led, ready_n, ready_led, rreq, wdog, wen, wsz;
  logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
  int errors = 0, n_tests = 0;

  bcr_bank #(.FUNCTION_CODE(FC), .VARIANT_CODE(VC), .REVISION_CODE(RC)) bcr_bank_i (
    .clk(clk), .reset(reset), .clk_en(clk_en), .io_addr(addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(wd), .io_rdata(rdat), .io_hit(hit),
    .sync_source_select(sel), .sync_direct_level(dir), .stop_state(stop),
    .timer_ch2(tmr), .speaker_enable(spk), .boot_mode_pins(boot), .sync_n(sync_n),
    .stop_n(stop_n), .stop_led_on(stop_led), .ready_n(ready_n), .ready_led_on(ready_led),
    .board_reset_req(rreq), .watchdog_enable(wdog), .window_enable(wen),
    .window_size(wsz), .window_page(wpg), .window_base(wbase), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
  bcr_sensor_model bcr_sensor_model_i (.scl_oe(scl_oe), .sda_oe(sda_oe),
    .hold_low(hold), .scl_line(scl_in), .sda_line(sda_in));

  // clock at 125 MHz
  initial forever #4 clk = ~clk;

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chkb
  // write; the pulse flag is checked at the cycle after the taking edge
  task wr(input logic [15:0] a, input logic [7:0] d, input logic p);
    addr = a; wd = d; io_wr = 1;
    @(negedge clk) chkb(rreq, p);
    io_wr = 0;
    @(negedge clk) chkb(rreq, 0);
  endtask : wr
  task rd(input logic [15:0] a, input logic [7:0] e);
    addr = a; io_rd = 1;
    @(negedge clk) io_rd = 0;
    @(negedge clk) chk(rdat, e);
  endtask : rd
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (4) @(negedge clk);
    reset = 0;
    @(negedge clk) chkb(ready_n, 1);
    chkb(stop_n, 0);
    rd(OFS_SETUP, 8'h00);
    rd(OFS_WIN_CFG, 8'h00);
    rd(OFS_WIN_BASE, 8'hC0);
    rd(OFS_TWO_WIRE, 8'hFF);
    wr(OFS_FUNCTION, 8'h00, 0);
    rd(OFS_FUNCTION, FC);
    rd(OFS_VARIANT, VC);
    wr(OFS_REVISION, 8'h00, 0);
    rd(OFS_REVISION, RC);
    wr(OFS_VARIANT, 8'h5A, 0);
    wr(OFS_VARIANT, 8'hA5, 1);
    wr(OFS_SETUP, 8'h80, 0);
    chkb(ready_led, 1);
    wr(OFS_SETUP, 8'hFF, 0);
    rd(OFS_SETUP, 8'hC0);
    wr(OFS_SETUP, 8'h00, 0);
    rd(OFS_SETUP, 8'h40);
    chkb(wdog, 1);
    chkb(ready_n, 1);
    wr(OFS_SETUP, 8'hC0, 0);
    stop = 0;
    #2 chkb(stop_led, 0);
    for (int b = 0; b < 4; b++)
    begin
      @(negedge clk) boot = b[1:0];
      #2 chkb(ready_n, b == 2);
      chkb(stop_led, b == 2);
      @(negedge clk) rd(OFS_BOOT, b[7:0]);
    end
    wr(OFS_WIN_CFG, 8'hFF, 0);
    rd(OFS_WIN_CFG, 8'h81);
    chkb(wen & wsz, 1);
    wr(OFS_WIN_PAGE, 8'hFD, 0);
    rd(OFS_WIN_PAGE, 8'h05);
    chk({5'h00, wpg}, 8'h05);
    clk_en = 0;
    wr(OFS_WIN_PAGE, 8'h02, 0);
    rd(OFS_FUNCTION, 8'h05);
    clk_en = 1;
    rd(OFS_WIN_PAGE, 8'h05);
    wr(OFS_WIN_BASE, 8'h15, 0);
    rd(OFS_WIN_BASE, 8'hD5);
    chk(wbase, 8'hD5);
    chkb(hit, 1);
    wr(OFS_TWO_WIRE, 8'h3F, 0);
    rd(OFS_TWO_WIRE, 8'h0F);
    wr(OFS_TWO_WIRE, 8'h80, 0);
    rd(OFS_TWO_WIRE, 8'hAF);
    chk({6'h00, scl_oe, sda_oe}, 8'h01);
    chkb(scl_out | sda_out, 0);
    hold = 1;
    wr(OFS_TWO_WIRE, 8'hC0, 0);
    rd(OFS_TWO_WIRE, 8'hEF);
    hold = 0;
    rd(16'h8203, 8'hFF);
    chkb(hit, 0);
    for (int i = 0; i < 16; i++)
    begin
      {sel, dir, tmr, spk} = i[3:0];
      #2 if (sel || dir) chkb(sync_n, sel ? dir : tmr & spk);
      @(negedge clk);
    end
    tally_and_finish();
  end
endmodule : bcr_bank_tb

bind bcr_bank bcr_bank_props #(.FUNCTION_CODE(FUNCTION_CODE)) bcr_bank_props_i (
  .clk(clk), .reset(reset), .clk_en(clk_en), .io_addr(io_addr), .io_rd(io_rd),
  .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
  .sync_source_select(sync_source_select), .sync_direct_level(sync_direct_level),
  .stop_state(stop_state), .timer_ch2(timer_ch2), .speaker_enable(speaker_enable),
  .boot_mode_pins(boot_mode_pins), .sync_n(sync_n), .stop_n(stop_n), .ready_n(ready_n),
  .board_reset_req(board_reset_req), .watchdog_enable(watchdog_enable),
  .window_base(window_base));
